// ### rtl/sar_result_buffer.sv
// top: result buffer with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module sar_result_buffer
    import result_buffer_pkg::*;
#(
    parameter int DEPTH_P = DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [result_buffer_pkg::ADDR_W-1:0] addr,
    input wire logic [result_buffer_pkg::DATA_W-1:0] wdata,
    input wire logic write,
    input wire logic read,
    output logic [result_buffer_pkg::DATA_W-1:0] rdata,
    // conversions from the scan sequencer
    input wire result_buffer_pkg::conversion_type conv,
    input wire logic port_scan,
    // per-source result words outside buffer mode
    output logic [result_buffer_pkg::RESULT_W-1:0] direct_result_reg [0:3],
    // interrupt
    output logic irq
);
    import result_buffer_pkg::*;

    logic buf_mode_reg;
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic pop_pending_reg;
    logic [1:0] rsel_reg;
    logic [DATA_W-1:0] misc_reg;
    logic tag;
    logic order_slip;
    entry_type wr_entry;
    entry_type rd_entry;

    wire is_full = (count_reg == (PTR_W+1)'(DEPTH_P));
    wire is_empty = (count_reg == '0);
    wire hit_buf = (addr == BUF_WORD_OFS);
    wire hit_ctrl = (addr == CTRL_OFS);
    wire hit_stat = (addr == STATUS_OFS);
    wire hit_istat = (addr == IRQ_STAT_OFS);
    wire hit_imask = (addr == IRQ_MASK_OFS);
    wire hit_level = (addr == LEVEL_OFS);
    wire pop = read && hit_buf && !is_empty;
    wire store_try = conv.valid && buf_mode_reg;
    wire push = store_try && (!is_full || pop);
    wire drop = store_try && !push;
    wire [PTR_W:0] count_next = count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    wire [IRQ_W-1:0] irq_events = {drop, push && (count_next == (PTR_W+1)'(DEPTH_P)), push};
    // set wins over a write-one clear in the same cycle
    wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg &
        ~((write && hit_istat) ? wdata[IRQ_W-1:0] : '0)) | irq_events;

    assign wr_entry = '{tag: tag, value: conv.value};

    scan_tagger tagger (
        .clock(clock),
        .rst_n(rst_n),
        .conv(conv),
        .port_scan(port_scan),
        .tag(tag),
        .order_slip_reg(order_slip)
    );

    result_store #(.WIDTH(RESULT_W+1), .ADDR(PTR_W)) store (
        .clock(clock),
        .wr_en(push),
        .wr_addr(wr_ptr_reg),
        .wr_data(wr_entry),
        .rd_addr(rd_ptr_reg),
        .rd_data(rd_entry)
    );

    // flags reflect the state after this pop, so the last read shows empty
    wire empty_after = (count_next == '0);
    wire full_after = (count_next == (PTR_W+1)'(DEPTH_P));

    // misc register read selection for non-buffer addresses
    wire [DATA_W-1:0] misc_data =
        hit_ctrl ? {{(DATA_W-1){1'b0}}, buf_mode_reg} :
        hit_stat ? {12'h000, order_slip, 1'b0, is_empty, is_full} :
        hit_istat ? {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg} :
        hit_imask ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg} :
        hit_level ? {{(DATA_W-PTR_W-1){1'b0}}, count_reg} : UNMAPPED_READ;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_mode_reg <= 1'b0;
            irq_mask_reg <= '0;
            irq_stat_reg <= '0;
            irq_reg <= 1'b0;
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (write && hit_ctrl)
            begin
                buf_mode_reg <= wdata[CTRL_BUF_MODE];
            end
            if (write && hit_imask)
            begin
                irq_mask_reg <= wdata[IRQ_W-1:0];
            end
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & ((write && hit_imask) ? wdata[IRQ_W-1:0] : irq_mask_reg));
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
        end
    end

    // outside buffer mode each result goes to its own location
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
            begin
                direct_result_reg[i] <= '0;
            end
        end
        else if (conv.valid && !buf_mode_reg)
        begin
            direct_result_reg[conv.source] <= conv.value;
        end
    end

    // read answer: memory data arrives one cycle later, flags captured now
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pop_pending_reg <= 1'b0;
            rsel_reg <= 2'h0;
            misc_reg <= BUF_WORD_RESET;
        end
        else
        begin
            pop_pending_reg <= pop;
            rsel_reg <= !read ? 2'h0 : (hit_buf ? 2'h1 : 2'h2);
            if (read && hit_buf)
            begin
                // empty buffer read returns flags only
                misc_reg <= {full_after && pop, empty_after, 14'h0000};
            end
            else
            begin
                misc_reg <= misc_data;
            end
        end
    end

    // word layout: full, empty, reserved zero, tag, result
    always_comb
    begin
        rdata_reg = '0;
        if (rsel_reg == 2'h1)
        begin
            rdata_reg = misc_reg;
            if (pop_pending_reg)
            begin
                rdata_reg[TAG_BIT] = rd_entry.tag;
                rdata_reg[RESULT_W-1:0] = rd_entry.value;
            end
        end
        else if (rsel_reg == 2'h2)
        begin
            rdata_reg = misc_reg;
        end
    end

    // hold a word between reads so the answer comes from a flop
    logic [DATA_W-1:0] hold_reg;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_reg <= BUF_WORD_RESET;
        end
        else if (rsel_reg != 2'h0)
        begin
            hold_reg <= rdata_reg;
        end
    end

    assign rdata = (rsel_reg != 2'h0) ? rdata_reg : hold_reg;
    assign irq = irq_reg;
endmodule // sar_result_buffer
`default_nettype wire

// ### rtl/result_buffer_pkg.sv
// package: constants and types for the conversion result buffer
package result_buffer_pkg;
    localparam int DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int RESULT_W = 12;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int FULL_BIT = 15;
    localparam int EMPTY_BIT = 14;
    localparam int RSVD_BIT = 13;
    localparam int TAG_BIT = 12;
    localparam logic [ADDR_W-1:0] BUF_WORD_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] LEVEL_OFS = 4'h5;
    // control register bits
    localparam int CTRL_BUF_MODE = 0;
    // interrupt bits: 0 result stored, 1 full, 2 overflow drop
    localparam int IRQ_W = 3;
    localparam int IRQ_STORED = 0;
    localparam int IRQ_FULL = 1;
    localparam int IRQ_OVF = 2;
    localparam logic [DATA_W-1:0] BUF_WORD_RESET = 16'h4000;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;
    typedef enum logic [1:0] {
        SRC_BATTERY = 2'h0,
        SRC_AUX_ONE = 2'h1,
        SRC_AUX_TWO = 2'h2,
        SRC_TEMP = 2'h3
    } source_type;
    typedef struct packed {
        logic valid;
        source_type source;
        logic [RESULT_W-1:0] value;
    } conversion_type;
    typedef struct packed {
        logic tag;
        logic [RESULT_W-1:0] value;
    } entry_type;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } bus_req_type;
endpackage

// ### rtl/result_store.sv
// result storage memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module result_store #(
    parameter int WIDTH = 13,
    parameter int ADDR = 6
) (
    // clock
    input wire logic clock,
    // write port
    input wire logic wr_en,
    input wire logic [ADDR-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [ADDR-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [0:(1<<ADDR)-1];
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // result_store
`default_nettype wire

// ### rtl/scan_tagger.sv
// maps a conversion source to its tag bit and checks scan order
`timescale 1ns/1ps
`default_nettype none
module scan_tagger
    import result_buffer_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // incoming conversion
    input wire result_buffer_pkg::conversion_type conv,
    input wire logic port_scan,
    // outputs
    output logic tag,
    output logic order_slip_reg
);
    // tag 1 for aux one or temperature, 0 for battery or aux two
    assign tag = (conv.source == SRC_AUX_ONE) || (conv.source == SRC_TEMP);
    logic [1:0] last_rank_reg;
    logic [1:0] rank;
    // ranks follow the sequencer order; a drop in rank starts a new scan
    assign rank = port_scan ? ((conv.source == SRC_BATTERY) ? 2'h0 :
                  (conv.source == SRC_AUX_ONE) ? 2'h1 : 2'h2)
                : ((conv.source == SRC_AUX_ONE) ? 2'h0 :
                  (conv.source == SRC_AUX_TWO) ? 2'h1 : 2'h2);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_rank_reg <= 2'h0;
            order_slip_reg <= 1'b0;
        end
        else if (conv.valid)
        begin
            last_rank_reg <= rank;
            // same nonzero rank twice in a row means order broke inside a scan
            order_slip_reg <= (rank == last_rank_reg) && (rank != 2'h0);
        end
    end
endmodule // scan_tagger
`default_nettype wire

// ### sim/sar_result_buffer_monitor.sv
// checker: result buffer port relations
`timescale 1ns/1ps
`default_nettype none
module sar_result_buffer_monitor
    import result_buffer_pkg::*;
#(
    parameter int DEPTH_P = DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [result_buffer_pkg::ADDR_W-1:0] addr,
    input wire logic [result_buffer_pkg::DATA_W-1:0] wdata,
    input wire logic write,
    input wire logic read,
    input wire logic [result_buffer_pkg::DATA_W-1:0] rdata,
    // conversions and outputs
    input wire result_buffer_pkg::conversion_type conv,
    input wire logic [result_buffer_pkg::RESULT_W-1:0] direct_result_reg [0:3],
    input wire logic irq
);
    logic mode_reg;
    logic [2:0] mask_reg;
    logic [7:0] lvl_reg;
    wire logic pop = read && addr == BUF_WORD_OFS && lvl_reg != 8'h00;
    // a pop frees room, so a push while full still lands
    wire logic push = conv.valid && mode_reg && (lvl_reg != 8'(DEPTH_P) || pop);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg <= 1'b0;
            mask_reg <= 3'h0;
            lvl_reg <= 8'h00;
        end
        else
        begin
            if (write && addr == CTRL_OFS)
                mode_reg <= wdata[CTRL_BUF_MODE];
            if (write && addr == IRQ_MASK_OFS)
                mask_reg <= wdata[2:0];
            lvl_reg <= lvl_reg + 8'(push) - 8'(pop);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence buf_read;
        read && addr == BUF_WORD_OFS;
    endsequence
    AST_EMPTY: assert property (buf_read |=> rdata[EMPTY_BIT] == (lvl_reg == 8'h00))
        else $error("empty flag wrong");
    AST_FULL: assert property (buf_read |=> rdata[FULL_BIT] == (lvl_reg == 8'(DEPTH_P)))
        else $error("full flag wrong");
    AST_RSVD: assert property (buf_read |=> !rdata[RSVD_BIT])
        else $error("reserved bit set");
    AST_EMPTY_WORD: assert property (buf_read ##0 (lvl_reg == 8'h00 && !conv.valid)
        |=> rdata == BUF_WORD_RESET) else $error("empty read word wrong");
    AST_LEVEL: assert property (read && addr == LEVEL_OFS && !conv.valid
        |=> rdata == 16'(lvl_reg)) else $error("fill level wrong");
    AST_STATUS: assert property (read && addr == STATUS_OFS && !conv.valid
        |=> rdata[1:0] == {lvl_reg == 8'h00, lvl_reg == 8'(DEPTH_P)}) else $error("status wrong");
    AST_DIRECT: assert property (conv.valid && !mode_reg
        |=> direct_result_reg[$past(conv.source)] == $past(conv.value)) else $error("direct wrong");
    AST_IRQ_MASKED: assert property (mask_reg == 3'h0 && $past(mask_reg) == 3'h0 |-> !irq)
        else $error("masked irq raised");
endmodule // sar_result_buffer_monitor
bind sar_result_buffer sar_result_buffer_monitor #(.DEPTH_P(DEPTH_P)) mon (.clock(clock),
    .rst_n(rst_n), .addr(addr), .wdata(wdata), .write(write), .read(read), .rdata(rdata),
    .conv(conv), .direct_result_reg(direct_result_reg), .irq(irq));
`default_nettype wire

// ### sim/scan_sequencer_model.sv
// scan sequencer model: emits conversions in scan order
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer_model
    import result_buffer_pkg::*;
(
    // clock
    input wire logic clock,
    // conversion output
    output var result_buffer_pkg::conversion_type conv
);
    initial conv = '0;
    // back to back conversions, the tightest spacing
    task automatic run(input logic ps, input logic [2:0] sel, input logic [11:0] v);
        for (int i = 0; i < 3; i++)
        begin
            if (ps || sel[i])
            begin
                @(posedge clock);
                conv <= '{1'b1, source_type'(2'(ps ? i : i + 1)), v + 12'(i)};
            end
        end
        @(posedge clock);
        conv <= '{1'b0, SRC_TEMP, ~v};
    endtask
endmodule // scan_sequencer_model
`default_nettype wire

// ### sim/sar_result_buffer_test.sv
// testbench: result buffer through register port and scan model
`timescale 1ns/1ps
`default_nettype none
module sar_result_buffer_test;
    import result_buffer_pkg::*;
    logic clock, rst_n, write, read, port_scan, irq;
    logic mode = 1'b0;
    logic seen = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    conversion_type conv;
    logic [RESULT_W-1:0] direct [0:3];
    logic [DATA_W-1:0] exp_q [$];
    logic [11:0] last_v = 12'h000;
    logic [12:0] fifo_q [$];
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'h0ECC;
    sar_result_buffer uut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .write(write), .read(read), .rdata(rdata), .conv(conv), .port_scan(port_scan),
        .direct_result_reg(direct), .irq(irq));
    scan_sequencer_model model (.clock(clock), .conv(conv));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic compare(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge clock);
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        addr <= a;
        read <= 1'b1;
        @(posedge clock);
        read <= 1'b0;
        @(posedge clock);
    endtask
    // answer appears in the cycle after the read and is held until the next read
    always @(posedge clock)
    begin
        if (seen)
            compare("rdata", exp_q.pop_front(), rdata);
        seen = read;
    end
    task automatic scan(input logic ps, input logic [2:0] sel);
        logic [11:0] v;
        v = 12'($random(seed));
        last_v = v;
        port_scan <= ps;
        for (int k = 0; k < 3; k++)
            if (mode && (ps || sel[k]) && fifo_q.size() < DEPTH)
                fifo_q.push_back({ps ? k == 1 : k != 1, v + 12'(k)});
        model.run(ps, sel, v);
    endtask
    task automatic drain;
        logic [12:0] e;
        while (fifo_q.size() > 0)
        begin
            e = fifo_q.pop_front();
            rd(BUF_WORD_OFS, {1'b0, fifo_q.size() == 0, 1'b0, e});
        end
        rd(BUF_WORD_OFS, BUF_WORD_RESET);
    endtask
    initial
    begin
        rst_n = 1'b0;
        write = 1'b0;
        read = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        port_scan = 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(BUF_WORD_OFS, BUF_WORD_RESET);
        rd(4'hF, UNMAPPED_READ);
        scan(1'b1, 3'h0);
        rd(LEVEL_OFS, 16'h0000);
        compare("direct0", {4'h0, last_v}, {4'h0, direct[0]});
        compare("direct1", {4'h0, last_v + 12'h001}, {4'h0, direct[1]});
        compare("direct2", {4'h0, last_v + 12'h002}, {4'h0, direct[2]});
        $display("test direct done");
        wr(IRQ_MASK_OFS, 16'h0007);
        wr(CTRL_OFS, 16'h0001);
        mode = 1'b1;
        scan(1'b1, 3'h0);
        scan(1'b0, 3'h5);
        repeat (2) @(posedge clock);
        compare("irq", 16'h0001, {15'h0000, irq});
        wr(IRQ_STAT_OFS, 16'h0007);
        @(posedge clock);
        compare("irq", 16'h0000, {15'h0000, irq});
        drain();
        $display("test order done");
        repeat (22) scan(1'b0, 3'h7);
        rd(STATUS_OFS, 16'h0001);
        rd(LEVEL_OFS, 16'h0040);
        rd(IRQ_STAT_OFS, 16'h0007);
        drain();
        $display("test fill done");
        close_out();
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule // sar_result_buffer_test
`default_nettype wire
